// File: hdl/icl_pkg.sv
// Constants for the information-code, transport-state and event-logger block.
// Assumes one 50 MHz system clock and an active-low total reset.
package icl_pkg;
  // Status word bit positions.
  localparam int unsigned B_SUPPLY_LOST   = 0;
  localparam int unsigned B_ON_BATTERY    = 1;
  localparam int unsigned B_EXT_ALARM     = 2;
  localparam int unsigned B_INLET_HI      = 3;
  localparam int unsigned B_OUTLET_HI     = 4;
  localparam int unsigned B_INLET_LO      = 5;
  localparam int unsigned B_OUTLET_LO     = 6;
  localparam int unsigned B_DELTA_T       = 7;
  localparam int unsigned B_F1_AIR        = 8;
  localparam int unsigned B_F1_REVERSE    = 9;
  localparam int unsigned B_F1_OVERFLOW   = 11;
  localparam int unsigned B_CHA_L1_LEAK   = 12;
  localparam int unsigned B_CHB_L1_LEAK   = 13;
  localparam int unsigned B_CHA_ALARM     = 14;
  localparam int unsigned B_CHB_ALARM     = 15;
  localparam int unsigned B_F1_COMM       = 16;
  localparam int unsigned B_F1_PULSE      = 17;
  localparam int unsigned B_CHA_L2_LEAK   = 18;
  localparam int unsigned B_CHB_L2_LEAK   = 19;
  localparam int unsigned B_AUX_HI        = 20;
  localparam int unsigned B_AUX_LO        = 21;
  localparam int unsigned B_F2_COMM       = 22;
  localparam int unsigned B_F2_PULSE      = 23;
  localparam int unsigned B_F2_AIR        = 24;
  localparam int unsigned B_F2_REVERSE    = 25;
  localparam int unsigned B_F2_OVERFLOW   = 27;
  localparam int unsigned B_BURST_LOSS    = 28;
  localparam int unsigned B_BURST_PEN     = 29;
  localparam int unsigned B_LEAK_LOSS     = 30;
  localparam int unsigned B_LEAK_PEN      = 31;

  // Word widths and reset values.
  localparam int unsigned WORD_W          = 32;
  localparam logic [31:0] STATUS_RST      = 32'h0000_0000;
  localparam int unsigned SENSE_W         = 30;  // Count of condition inputs.

  // Logger geometry.
  localparam int unsigned LOG_DEPTH       = 280;
  localparam int unsigned LOG_SHOWN       = 50;
  localparam int unsigned LOG_AW          = 9;
  localparam logic [8:0]  LOG_LAST        = 9'h117;  // LOG_DEPTH - 1.
  localparam logic [8:0]  LOG_SHOWN_W     = 9'h032;  // LOG_SHOWN as address width.
  localparam int unsigned REC_W           = 32*6;

  // Flow threshold, in percent of nominal flow.
  localparam logic [7:0]  FLOW_PCT        = 8'h01;
  localparam logic [7:0]  PCT_FULL        = 8'h64;

  // Indicator blink half period.
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BLINK_MS        = 500;
  localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;

  // Transport machine states.
  typedef enum logic [0:0] {
    ST_TRANSPORT = 1'b0,
    ST_ACTIVE    = 1'b1
  } icl_state_t;
endpackage

// File: hdl/icl_sync.sv
// Three-flop input synchroniser with agreement of the last two stages.
// Assumes the input comes from a pin outside the system clock domain.
`timescale 1ns/1ps
module icl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_q;  // First stage, read only by the second.
  logic [W-1:0] s2_q;  // Second stage.
  logic [W-1:0] s3_q;  // Third stage.

  // Shift the pin through three stages.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only when the last two stages agree, which rejects a lone glitch.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // icl_sync

// File: hdl/icl_logger.sv
// Status word, transport state, radio gate, event counter and event logger.
// Assumes sensor flags, keys and seals arrive as asynchronous pins; the clock and
// energy totals come from same-clock logic; readers address the log directly.
`timescale 1ns/1ps
module icl_logger
  import icl_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  // Condition pins, in status-bit order with bits 10 and 26 left out.
  input  wire logic [SENSE_W-1:0] cond_i,
  input  wire logic [31:0]        event_enable_i,     // Country configuration mask.
  input  wire logic [7:0]         flow_pct_i,         // First flow as percent of nominal.
  input  wire logic               finish_config_i,    // End-of-setup command, pin.
  input  wire logic               base_separated_i,   // Top and base apart, pin.
  input  wire logic               setup_radio_on_i,   // Radio enabled in setup, pin.
  input  wire logic               call_keys_i,        // Both arrow keys held, pin.
  input  wire logic               test_mode_i,        // Test loop entered, pin.
  input  wire logic               show_status_i,      // Display shows status word, pin.
  input  wire logic [31:0]        date_i,             // Same-clock calendar date.
  input  wire logic [31:0]        time_i,             // Same-clock time of day.
  input  wire logic [31:0]        heat_energy_total_i,
  input  wire logic [31:0]        cooling_energy_total_i,
  input  wire logic [31:0]        volume_total_i,
  input  wire logic [8:0]         log_rd_age_i,       // 0 is the newest record.
  input  wire logic               log_rd_display_i,   // Read on behalf of the display.
  output logic [31:0]             meter_alarm_status_word_o,
  output logic [31:0]             event_count_o,
  output logic                    transport_o,
  output logic                    setup_open_o,
  output logic                    radio_on_o,
  output logic                    info_led_o,
  output logic [REC_W-1:0]        log_rd_rec_o,
  output logic                    log_rd_valid_o,
  output logic [8:0]              log_fill_o
);
  // Six single pins ride on top of the condition flags in one synchroniser.
  localparam int unsigned PIN_W = SENSE_W + 6;

  logic [PIN_W-1:0] pin_s;       // Synchronised pins.
  logic [SENSE_W-1:0] cond_s;    // Synchronised condition flags.
  logic fin_s;                   // Synchronised end-of-setup level.
  logic sep_s;                   // Synchronised separation level.
  logic srad_s;                  // Synchronised setup radio enable.
  logic call_s;                  // Synchronised forced call.
  logic test_s;                  // Synchronised test mode.
  logic show_s;                  // Synchronised display selection.
  logic fin_prev_q;              // Last end-of-setup level, for its edge.
  logic call_prev_q;             // Last call level, for its edge.
  logic [31:0] word_d;           // Status word built from the flags.
  logic [31:0] word_q;           // Registered status word.
  logic changed;                 // Some enabled bit differs this cycle.
  logic log_event;               // An event that counts and logs.
  logic flow_seen;               // Flow at or above the threshold.
  logic flow_first_q;            // Flow has been seen once since reset.
  icl_state_t state_q;           // Transport machine.
  logic [31:0] count_q;          // Event counter.
  logic [REC_W-1:0] log_mem [LOG_DEPTH];  // Record store.
  logic [8:0] wr_ptr_q;          // Next slot to write.
  logic [8:0] fill_q;            // Records held, saturating at the depth.
  logic [8:0] rd_idx;            // Slot of the requested record.
  logic rd_ok;                   // Requested record exists and may be seen.
  logic [31:0] blink_cnt_q;      // Blink half-period counter.
  logic blink_q;                 // Blink phase.

  // All pin inputs share one synchroniser instance.
  icl_sync #(
    .W(PIN_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({show_status_i, test_mode_i, call_keys_i, setup_radio_on_i,
                 base_separated_i, finish_config_i, cond_i}),
    .sync_o    (pin_s)
  );

  assign cond_s = pin_s[SENSE_W-1:0];
  assign fin_s  = pin_s[SENSE_W];
  assign sep_s  = pin_s[SENSE_W+1];
  assign srad_s = pin_s[SENSE_W+2];
  assign call_s = pin_s[SENSE_W+3];
  assign test_s = pin_s[SENSE_W+4];
  assign show_s = pin_s[SENSE_W+5];

  // Spread the condition flags onto their status-bit positions.
  always_comb begin
    word_d = STATUS_RST;
    word_d[B_SUPPLY_LOST] = cond_s[0];
    word_d[B_ON_BATTERY]  = cond_s[1];
    word_d[B_EXT_ALARM]   = cond_s[2];
    word_d[B_INLET_HI]    = cond_s[3];
    word_d[B_OUTLET_HI]   = cond_s[4];
    word_d[B_INLET_LO]    = cond_s[5];
    word_d[B_OUTLET_LO]   = cond_s[6];
    word_d[B_DELTA_T]     = cond_s[7];
    word_d[B_F1_AIR]      = cond_s[8];
    word_d[B_F1_REVERSE]  = cond_s[9];
    // Input index 10 maps to bit 11; bit 10 stays zero.
    word_d[B_F1_OVERFLOW] = cond_s[10];
    word_d[B_CHA_L1_LEAK] = cond_s[11];
    word_d[B_CHB_L1_LEAK] = cond_s[12];
    word_d[B_CHA_ALARM]   = cond_s[13];
    word_d[B_CHB_ALARM]   = cond_s[14];
    word_d[B_F1_COMM]     = cond_s[15];
    word_d[B_F1_PULSE]    = cond_s[16];
    word_d[B_CHA_L2_LEAK] = cond_s[17];
    word_d[B_CHB_L2_LEAK] = cond_s[18];
    word_d[B_AUX_HI]      = cond_s[19];
    word_d[B_AUX_LO]      = cond_s[20];
    word_d[B_F2_COMM]     = cond_s[21];
    word_d[B_F2_PULSE]    = cond_s[22];
    word_d[B_F2_AIR]      = cond_s[23];
    word_d[B_F2_REVERSE]  = cond_s[24];
    // Bit 26 stays zero.
    word_d[B_F2_OVERFLOW] = cond_s[25];
    word_d[B_BURST_LOSS]  = cond_s[26];
    word_d[B_BURST_PEN]   = cond_s[27];
    word_d[B_LEAK_LOSS]   = cond_s[28];
    // Penetration has its own flag, so loss and penetration never mirror each other.
    word_d[B_LEAK_PEN]    = cond_s[29];
  end

  // Flow threshold is a fraction of nominal flow; percent input keeps it exact.
  assign flow_seen = (flow_pct_i >= FLOW_PCT);

  // Only bits the country configuration enables raise an event.
  assign changed   = |((word_d ^ word_q) & event_enable_i);
  // Events are dropped in transport state or while the parts are apart.
  assign log_event = changed && (state_q == ST_ACTIVE) && !sep_s;

  // The word itself always follows the flags, so the display stays current.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_q <= STATUS_RST;
    end else begin
      word_q <= word_d;
    end
  end

  // Edge memories for the command and the call keys.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fin_prev_q  <= 1'b0;
      call_prev_q <= 1'b0;
    end else begin
      fin_prev_q  <= fin_s;
      call_prev_q <= call_s;
    end
  end

  // Transport machine: leaves on first flow or end of setup, never comes back.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_TRANSPORT;
    end else begin
      case (state_q)
        ST_TRANSPORT: begin
          if (flow_seen || (fin_s && !fin_prev_q)) begin
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          state_q <= ST_ACTIVE;
        end
        default: begin
          state_q <= ST_TRANSPORT;
        end
      endcase
    end
  end

  // Setup access: open in transport, closed by the command, reopened by separation.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup_open_o <= 1'b1;
    end else if (sep_s) begin
      setup_open_o <= 1'b1;
    end else if (fin_s && !fin_prev_q) begin
      setup_open_o <= 1'b0;
    end else if (state_q == ST_TRANSPORT) begin
      setup_open_o <= 1'b1;
    end
  end

  // First-flow memory. It is kept apart from the transport machine because the
  // finish command may end transport before any flow has ever been seen, and the
  // radio must still come on at that later first detection.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flow_first_q <= 1'b0;
    end else if (flow_seen) begin
      flow_first_q <= 1'b1;
    end
  end

  // Radio gate. Test mode wins over every way to switch it on.
  // A first detection that falls inside test mode is used up and leaves the radio off.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      radio_on_o <= 1'b0;
    end else if (test_s) begin
      radio_on_o <= 1'b0;
    end else if (flow_seen && !flow_first_q) begin
      radio_on_o <= 1'b1;
    end else if (srad_s || (call_s && !call_prev_q)) begin
      // Does not touch the transport machine.
      radio_on_o <= 1'b1;
    end
  end

  // Event counter, zero from reset, one step per counted change.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= 32'h0000_0000;
    end else if (log_event) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // Record write: circular store, oldest overwritten once full.
  always_ff @(posedge sys_clk_i) begin
    if (log_event) begin
      log_mem[wr_ptr_q] <= {date_i, time_i, word_d, heat_energy_total_i,
                            cooling_energy_total_i, volume_total_i};
    end
  end

  // Write pointer and fill level.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= 9'h000;
      fill_q   <= 9'h000;
    end else if (log_event) begin
      wr_ptr_q <= (wr_ptr_q == LOG_LAST) ? 9'h000 : wr_ptr_q + 9'h001;
      if (fill_q != LOG_LAST + 9'h001) begin
        fill_q <= fill_q + 9'h001;
      end
    end
  end

  // Slot of the record that is the given age back from the newest.
  always_comb begin
    rd_idx = 9'h000;
    if (log_rd_age_i < wr_ptr_q) begin
      rd_idx = wr_ptr_q - 9'h001 - log_rd_age_i;
    end else begin
      rd_idx = LOG_LAST + wr_ptr_q - log_rd_age_i;
    end
  end

  // The display window stops at the latest fifty; serial reads see all.
  assign rd_ok = (log_rd_age_i < fill_q)
              && (!log_rd_display_i || log_rd_age_i < LOG_SHOWN_W);

  // Registered read port, one cycle after the age is presented.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      log_rd_rec_o   <= '0;
      log_rd_valid_o <= 1'b0;
    end else begin
      log_rd_valid_o <= rd_ok;
      log_rd_rec_o   <= rd_ok ? log_mem[rd_idx] : '0;
    end
  end

  // Blink timebase for the indicator.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // Indicator and mirrored outputs, all from flops.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      info_led_o                <= 1'b0;
      meter_alarm_status_word_o <= STATUS_RST;
      event_count_o             <= 32'h0000_0000;
      transport_o               <= 1'b1;
      log_fill_o                <= 9'h000;
    end else begin
      info_led_o                <= (word_q != STATUS_RST) && (show_s || blink_q);
      meter_alarm_status_word_o <= word_q;
      event_count_o             <= count_q;
      transport_o               <= (state_q == ST_TRANSPORT);
      log_fill_o                <= fill_q;
    end
  end
endmodule // icl_logger

// File: verif/icl_logger_properties.sv
// Concurrent checks on the status word, transport, radio and log read ports.
// Assumes it is bound onto icl_logger and sees only that module's ports.
`timescale 1ns/1ps
module icl_logger_properties
  import icl_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic [SENSE_W-1:0] cond_i,
  input wire logic        test_mode_i,
  input wire logic        show_status_i,
  input wire logic        base_separated_i,
  input wire logic [8:0]  log_rd_age_i,
  input wire logic        log_rd_display_i,
  input wire logic [31:0] meter_alarm_status_word_o,
  input wire logic [31:0] event_count_o,
  input wire logic        transport_o,
  input wire logic        setup_open_o,
  input wire logic        radio_on_o,
  input wire logic        info_led_o,
  input wire logic        log_rd_valid_o
);
  // One clock domain, so one clocking and one reset serve every check.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Pin checks allow six cycles: three sync flops, agreement and a register.
  property p_transport_sticky; !transport_o |=> !transport_o; endproperty
  a_transport_sticky: assert property (p_transport_sticky) else $error("transport re-entered");
  property p_count_hold; transport_o [*3] |-> $stable(event_count_o); endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved in transport");
  property p_count_step;
    $changed(event_count_o) |-> event_count_o == $past(event_count_o) + 32'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step not one");
  property p_free_bits;
    meter_alarm_status_word_o[10] == 1'b0 && meter_alarm_status_word_o[26] == 1'b0;
  endproperty
  a_free_bits: assert property (p_free_bits) else $error("unassigned bit set");
  // The word passes one more register than the radio, so a held flag needs seven cycles.
  property p_leak_pair;
    cond_i[SENSE_W-1] [*7] |-> meter_alarm_status_word_o[31];
  endproperty
  a_leak_pair: assert property (p_leak_pair) else $error("penetration bit missing");
  property p_test_radio; test_mode_i [*6] |-> !radio_on_o; endproperty
  a_test_radio: assert property (p_test_radio) else $error("radio on in test");
  property p_sep_setup; base_separated_i [*6] |-> setup_open_o; endproperty
  a_sep_setup: assert property (p_sep_setup) else $error("setup shut while apart");
  property p_led_shown;
    show_status_i [*6] ##0 (meter_alarm_status_word_o != 32'h0) [*2] |-> info_led_o;
  endproperty
  a_led_shown: assert property (p_led_shown) else $error("indicator not steady");
  property p_led_off; (meter_alarm_status_word_o == 32'h0) [*3] |-> !info_led_o; endproperty
  a_led_off: assert property (p_led_off) else $error("indicator lit on zero");
  property p_disp_limit;
    log_rd_display_i && log_rd_age_i >= LOG_SHOWN_W |=> !log_rd_valid_o;
  endproperty
  a_disp_limit: assert property (p_disp_limit) else $error("display read too old");

  // Main scenarios: an event counted, transport left, indicator shown.
  c_count: cover property ($changed(event_count_o));
  c_left: cover property ($fell(transport_o));
  c_led: cover property (info_led_o && show_status_i);
endmodule // icl_logger_properties

bind icl_logger icl_logger_properties i_icl_logger_properties (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cond_i(cond_i), .test_mode_i(test_mode_i),
  .show_status_i(show_status_i), .base_separated_i(base_separated_i),
  .log_rd_age_i(log_rd_age_i), .log_rd_display_i(log_rd_display_i),
  .meter_alarm_status_word_o(meter_alarm_status_word_o), .event_count_o(event_count_o),
  .transport_o(transport_o), .setup_open_o(setup_open_o), .radio_on_o(radio_on_o),
  .info_led_o(info_led_o), .log_rd_valid_o(log_rd_valid_o)
);

// File: verif/icl_reader.sv
// Serial reader model that fetches event log records one at a time.
// Assumes the logger answers a presented age on the next rising edge.
`timescale 1ns/1ps
module icl_reader
  import icl_pkg::*;
(
  input  wire logic [0:0]       sys_clk_i,
  input  wire logic [REC_W-1:0] rec_i,
  input  wire logic             valid_i,
  output logic      [8:0]       age_o,
  output logic                  display_o
);
  // Idle with the newest record selected on the serial side.
  initial begin
    age_o = 9'h000;
    display_o = 1'b0;
  end
  // Change off the edge and hold across the answering edge, so no race.
  task automatic read(input logic [8:0] age, input logic disp,
                      output logic [REC_W-1:0] rec, output logic vld);
    @(negedge sys_clk_i);
    age_o = age;
    display_o = disp;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rec = rec_i;
    vld = valid_i;
  endtask
endmodule // icl_reader

// File: verif/tb_info_code_transport_logger.sv
// Self-checking bench for the status word, transport state and event log.
// Assumes the package, logger and reader model are compiled before it.
`timescale 1ns/1ps
module tb_info_code_transport_logger;
  import icl_pkg::*;
  // Fixed stamp data; the word slice is filled in per record.
  localparam logic [31:0] DT = 32'h0001_0203;
  localparam logic [31:0] TM = 32'h0004_0506;
  localparam logic [31:0] HE = 32'h0000_0a0b;
  localparam logic [31:0] CE = 32'h0000_0c0d;
  localparam logic [31:0] VO = 32'h0000_0e0f;
  logic sys_clk_i, nrst_i, fin, sep, srad, keys, test, show, disp, valid, trans, setup, radio, led;
  logic [29:0]      cond;
  logic [31:0]      en, word, count;
  logic [7:0]       flow;
  logic [8:0]       age, fill;
  logic [REC_W-1:0] rec;
  int               miscompares, samples_checked, ev;

  icl_logger i_icl_logger (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cond_i(cond),
    .event_enable_i(en), .flow_pct_i(flow), .finish_config_i(fin), .base_separated_i(sep),
    .setup_radio_on_i(srad), .call_keys_i(keys), .test_mode_i(test), .show_status_i(show),
    .date_i(DT), .time_i(TM), .heat_energy_total_i(HE), .cooling_energy_total_i(CE),
    .volume_total_i(VO), .log_rd_age_i(age), .log_rd_display_i(disp),
    .meter_alarm_status_word_o(word), .event_count_o(count), .transport_o(trans),
    .setup_open_o(setup), .radio_on_o(radio), .info_led_o(led), .log_rd_rec_o(rec),
    .log_rd_valid_o(valid), .log_fill_o(fill));
  icl_reader i_icl_reader (.sys_clk_i(sys_clk_i), .rec_i(rec), .valid_i(valid),
    .age_o(age), .display_o(disp));

  // Free-running 50 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Pin changes land after a few cycles; a word that never shows ends the run.
  task automatic wait_word(input logic [31:0] exp);
    for (int i = 0; i < 20 && word !== exp; i++) @(negedge sys_clk_i);
    if (word !== exp) begin
      miscompares++;
      $display("BAD %0t: word stuck at %h", $time, word);
      tally_and_finish();
    end
    settle(2);
  endtask
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    nrst_i = 1'b1;
  endtask
  // Where each condition input shows in the word; bits 10 and 26 are skipped.
  function automatic logic [31:0] map(input int k);
    if (k < 10) return 32'h1 << k;
    if (k < 25) return 32'h1 << (k + 1);
    return 32'h1 << (k + 2);
  endfunction
  task automatic chk_rec(input logic [8:0] a, input logic [31:0] w);
    logic [REC_W-1:0] r;
    logic             v;
    i_icl_reader.read(a, 1'b0, r, v);
    chkb(v, 1'b1);
    chk(r[191:160], DT);
    chk(r[159:128], TM);
    chk(r[127:96], w);
    chk(r[95:64], HE);
    chk(r[63:32], CE);
    chk(r[31:0], VO);
  endtask
  task automatic chk_vld(input logic [8:0] a, input logic d, input logic exp);
    logic [REC_W-1:0] r;
    logic             v;
    i_icl_reader.read(a, d, r, v);
    chkb(v, exp);
  endtask

  initial begin
    {fin, sep, srad, keys, test, show} = 6'h00;
    cond = 30'h0;
    en = 32'hffff_ffff;
    flow = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    do_reset();
    chk(word, 32'h0);
    chk(count, 32'h0);
    chkb(trans, 1'b1);
    chkb(setup, 1'b1);
    chkb(radio, 1'b0);
    // A change in transport shows in the word but is neither counted nor logged.
    cond[3] = 1'b1;
    wait_word(32'h8);
    chk(count, 32'h0);
    chk({23'h0, fill}, 32'h0);
    srad = 1'b1;
    settle(8);
    chkb(radio, 1'b1);
    chkb(trans, 1'b1);
    fin = 1'b1;
    settle(8);
    fin = 1'b0;
    chkb(trans, 1'b0);
    chkb(setup, 1'b0);
    // Separation reopens setup and suppresses events.
    sep = 1'b1;
    settle(8);
    chkb(setup, 1'b1);
    cond[0] = 1'b1;
    wait_word(32'h9);
    chk(count, 32'h0);
    sep = 1'b0;
    settle(8);
    // Walk every condition twice, each step one counted event.
    ev = 0;
    repeat (2) begin
      for (int k = 0; k < 30; k++) begin
        cond = 30'h1 << k;
        wait_word(map(k));
        ev++;
        chk(word, map(k));
        chk(count, ev);
      end
    end
    show = 1'b1;
    settle(8);
    chkb(led, 1'b1);
    show = 1'b0;
    chk({23'h0, fill}, ev);
    chk_rec(9'd0, map(29));
    chk_rec(9'd1, map(28));
    chk_vld(9'd49, 1'b1, 1'b1);
    chk_vld(9'd50, 1'b1, 1'b0);
    chk_vld(9'd50, 1'b0, 1'b1);
    chk_vld(9'd60, 1'b0, 1'b0);
    // A masked change updates the word only.
    en = 32'h0;
    cond = 30'h0;
    wait_word(32'h0);
    chk(count, ev);
    test = 1'b1;
    settle(8);
    chkb(radio, 1'b0);
    keys = 1'b1;
    settle(8);
    keys = 1'b0;
    chkb(radio, 1'b0);
    // Only a total reset brings transport back; flow then ends it.
    {test, srad} = 2'b00;
    en = 32'hffff_ffff;
    // Out of test mode a forced call switches the radio on again.
    settle(8);
    keys = 1'b1;
    settle(8);
    keys = 1'b0;
    chkb(radio, 1'b1);
    do_reset();
    chkb(trans, 1'b1);
    chk(count, 32'h0);
    flow = FLOW_PCT;
    settle(4);
    chkb(trans, 1'b0);
    chkb(radio, 1'b1);
    cond[4] = 1'b1;
    wait_word(32'h10);
    chk(count, 32'h1);
    tally_and_finish();
  end
endmodule // tb_info_code_transport_logger
